// File: sasp_port.sv
// Serial port and conversion sequencer of a 10-bit serial ADC
`timescale 1ns/1ps
//
// Behaviour
// - Internal variant accepts select right after completion
// - Deselected: output floats, clock and data ignored
// - Select fall restarts the serial port
// - External: select needs two conversion clock falls
// - Internal: select level must persist 2 ms
// - Select during conversion aborts, result kept
// - Conversion end writes result; late abort risky
// - Selected: drive previous result MSB
// - First transfer after power-up undefined
// - Next bit on each fall, MSB first
// - Tenth fall onward drives zero
// - Held select: new MSB at 16th or completion
// - Address on first four rises, then ignored
// - Three events start a transfer
// - Sample falls four to ten, then hold
// - Long transfer needs rise before completion
// - At least ten static clocks per transfer
// - Internal: completion flag low at tenth fall
// - External: conversion takes 44 conversion clocks

module sasp_port #(
  parameter bit INTERNAL_OSC = 1'b0,                   // 1: internal oscillator variant
  parameter int CS_FILT_CYC  = sasp_pkg::CS_FILT_CYC_DEF,
  parameter int CONV_CYC     = sasp_pkg::CONV_CYC_DEF
) (
  input  wire logic                        clk,
  input  wire logic                        rstn,
  input  wire logic                        sclk,
  input  wire logic                        cs_n,
  input  wire logic                        din,
  input  wire logic                        conversion_clock,
  input  wire logic [sasp_pkg::RES_W-1:0]  conv_result,
  output logic                             dout,
  output logic                             dout_oe_n,
  output logic                             eoc,
  output logic                             data_undefined,
  output sasp_pkg::sasp_ana_t              ana
);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Binary to gray
  function automatic logic [3:0] b2g(input logic [3:0] b);
    return b ^ (b >> 1);
  endfunction

  // Gray to binary
  function automatic logic [3:0] g2b(input logic [3:0] g);
    logic [3:0] b;
    b = g;
    for (int i = 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction

  // ---------------------------------------------------------------
  // Serial clock domain
  // ---------------------------------------------------------------
  logic [3:0] rise_bin_q;   // Rising edges seen
  logic [3:0] rise_gray_q;  // Same, gray coded for crossing
  logic [3:0] fall_bin_q;   // Falling edges seen
  logic [3:0] fall_gray_q;  // Same, gray coded for crossing
  logic [7:0] ring_q;       // Data input captured per rise

  // Rise counter; clock may stop, so reset acts without it
  always_ff @(posedge sclk or negedge rstn) begin
    if (!rstn) begin
      rise_bin_q  <= 4'h0;
      rise_gray_q <= 4'h0;
    end else begin
      rise_bin_q  <= rise_bin_q + 4'h1;
      rise_gray_q <= b2g(rise_bin_q + 4'h1);
    end
  end

  // Data bit captured on every rise, written before pointer moves
  always_ff @(posedge sclk or negedge rstn) begin
    if (!rstn) begin
      ring_q <= 8'h00;
    end else begin
      ring_q[rise_bin_q[2:0]] <= din;
    end
  end

  // Fall counter
  always_ff @(negedge sclk or negedge rstn) begin
    if (!rstn) begin
      fall_bin_q  <= 4'h0;
      fall_gray_q <= 4'h0;
    end else begin
      fall_bin_q  <= fall_bin_q + 4'h1;
      fall_gray_q <= b2g(fall_bin_q + 4'h1);
    end
  end

  // ---------------------------------------------------------------
  // Synchronisers into clk
  // ---------------------------------------------------------------
  logic [3:0] rise_s1_q, rise_s2_q;  // Rise pointer sync
  logic [3:0] fall_s1_q, fall_s2_q;  // Fall pointer sync
  logic       cs_s1_q, cs_s2_q;      // Chip select sync
  logic       cc_s1_q, cc_s2_q;      // Conversion clock sync
  logic       cc_d_q;                // Conversion clock delayed

  // Two flops for each pointer, select and conversion clock
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rise_s1_q <= 4'h0;
      rise_s2_q <= 4'h0;
      fall_s1_q <= 4'h0;
      fall_s2_q <= 4'h0;
      cs_s1_q   <= 1'b1;
      cs_s2_q   <= 1'b1;
      cc_s1_q   <= 1'b0;
      cc_s2_q   <= 1'b0;
      cc_d_q    <= 1'b0;
    end else begin
      rise_s1_q <= rise_gray_q;
      rise_s2_q <= rise_s1_q;
      fall_s1_q <= fall_gray_q;
      fall_s2_q <= fall_s1_q;
      cs_s1_q   <= cs_n;
      cs_s2_q   <= cs_s1_q;
      cc_s1_q   <= conversion_clock;
      cc_s2_q   <= cc_s1_q;
      cc_d_q    <= cc_s2_q;
    end
  end

  // ---------------------------------------------------------------
  // Edge events in clk
  // ---------------------------------------------------------------
  logic [3:0] rise_b, fall_b;          // Decoded pointers
  logic [3:0] rise_prev_q, fall_prev_q; // Last seen pointers
  logic       rise_ev, fall_ev;        // One serial edge seen
  logic       cc_fall;                 // Conversion clock fall
  logic       ring_bit;                // Bit of the latest rise

  assign rise_b   = g2b(rise_s2_q);
  assign fall_b   = g2b(fall_s2_q);
  assign rise_ev  = rise_b != rise_prev_q;
  assign fall_ev  = fall_b != fall_prev_q;
  assign cc_fall  = cc_d_q & ~cc_s2_q;
  assign ring_bit = ring_q[3'(rise_b - 4'h1)];

  // Track last pointer values
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rise_prev_q <= 4'h0;
      fall_prev_q <= 4'h0;
    end else begin
      rise_prev_q <= rise_b;
      fall_prev_q <= fall_b;
    end
  end

  // ---------------------------------------------------------------
  // Chip select qualification
  // ---------------------------------------------------------------
  localparam logic [19:0] CS_LIM = INTERNAL_OSC ? 20'(CS_FILT_CYC - 1) : 20'(sasp_pkg::CS_EDGES - 1);
  logic [19:0] filt_cnt_q;  // Persistence count
  logic        cs_lvl_q;    // Qualified chip select level
  logic        cs_step;     // One persistence step
  logic        accept;      // New level qualified
  logic        qual_fall;   // Valid select
  logic        qual_rise;   // Valid deselect
  logic        cs_sel;      // Qualified selected

  assign cs_step   = INTERNAL_OSC ? 1'b1 : cc_fall;
  assign accept    = (cs_s2_q != cs_lvl_q) && cs_step && (filt_cnt_q == CS_LIM);
  assign qual_fall = accept & ~cs_s2_q;
  assign qual_rise = accept & cs_s2_q;
  assign cs_sel    = ~cs_lvl_q;

  // Filter runs in every state, even right after completion
  always_ff @(posedge clk) begin
    if (!rstn) begin
      filt_cnt_q <= 20'h00000;
      cs_lvl_q   <= 1'b1;
    end else if (cs_s2_q == cs_lvl_q) begin
      filt_cnt_q <= 20'h00000;                // Glitch restarts count
    end else if (accept) begin
      filt_cnt_q <= 20'h00000;
      cs_lvl_q   <= cs_s2_q;
    end else if (cs_step) begin
      filt_cnt_q <= filt_cnt_q + 20'h00001;
    end
  end

  // ---------------------------------------------------------------
  // Transfer sequencer
  // ---------------------------------------------------------------
  localparam logic [13:0] CONV_LIM = INTERNAL_OSC ? 14'(CONV_CYC - 1) : 14'(sasp_pkg::CONV_STEPS - 1);
  localparam logic [4:0]  POS_TEN  = 5'(sasp_pkg::XFER_SHORT);
  localparam logic [4:0]  POS_LONG = 5'(sasp_pkg::XFER_LONG);
  localparam logic [4:0]  POS_SMP  = 5'(sasp_pkg::SAMPLE_POS);
  sasp_pkg::sasp_state_t  state_q;   // Sequencer state
  logic [4:0]  pos_q;                // Falls since transfer start
  logic [2:0]  rpos_q;               // Rises since start, saturating
  logic        rise10_q;             // Rise seen after tenth fall
  logic [13:0] conv_cnt_q;           // Conversion progress
  logic        conv_step;            // One conversion step
  logic        conv_done;            // Last conversion step
  logic        enter_conv;           // Tenth fall in shifting
  logic        tail_start;           // 16th fall of a long transfer
  logic        start_port;           // New transfer begins

  assign conv_step  = INTERNAL_OSC ? 1'b1 : cc_fall;
  assign conv_done  = (state_q == sasp_pkg::ST_CONV) && conv_step && (conv_cnt_q == CONV_LIM);
  assign tail_start = (state_q == sasp_pkg::ST_TAIL) && fall_ev && cs_sel && (pos_q == POS_LONG - 5'd1);
  // Select fall, completion with select held, or 16th fall
  assign start_port = qual_fall
                    | (conv_done & cs_sel & (~rise10_q | (pos_q >= POS_LONG)))
                    | tail_start;
  assign enter_conv = (state_q == sasp_pkg::ST_SHIFT) && fall_ev && cs_sel && (pos_q == POS_TEN - 5'd1);

  // State, fall position and rise bookkeeping
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_q  <= sasp_pkg::ST_IDLE;
      pos_q    <= 5'd0;
      rpos_q   <= 3'd0;
      rise10_q <= 1'b0;
    end else if (start_port) begin
      // Realign to the host stream; abort a running conversion
      state_q  <= sasp_pkg::ST_SHIFT;
      pos_q    <= 5'd0;
      rpos_q   <= 3'd0;
      rise10_q <= 1'b0;
    end else begin
      // Serial edges count only while selected
      if (fall_ev && cs_sel && (state_q != sasp_pkg::ST_IDLE) && (pos_q != 5'd31)) begin
        pos_q <= pos_q + 5'd1;
      end
      if (rise_ev && cs_sel && (rpos_q != 3'd4)) begin
        rpos_q <= rpos_q + 3'd1;
      end
      // Rise during conversion keeps a long transfer in step
      if (rise_ev && cs_sel && ((state_q == sasp_pkg::ST_CONV) || (state_q == sasp_pkg::ST_TAIL))) begin
        rise10_q <= 1'b1;
      end
      unique case (state_q)
        sasp_pkg::ST_IDLE: begin
          state_q <= sasp_pkg::ST_IDLE;       // Waits for a valid select
        end
        sasp_pkg::ST_SHIFT: begin
          if (enter_conv) begin
            state_q <= sasp_pkg::ST_CONV;     // Tenth fall under select wins
          end else if (qual_rise) begin
            state_q <= sasp_pkg::ST_IDLE;     // Short transfer dropped
          end
        end
        sasp_pkg::ST_CONV: begin
          if (conv_done) begin
            // Longer than conversion waits for 16th fall
            state_q <= (cs_sel && rise10_q && (pos_q < POS_LONG)) ? sasp_pkg::ST_TAIL : sasp_pkg::ST_IDLE;
          end
        end
        sasp_pkg::ST_TAIL: begin
          if (qual_rise) begin
            state_q <= sasp_pkg::ST_IDLE;     // Transfer ended by deselect
          end
        end
      endcase
    end
  end

  // Conversion step counter
  always_ff @(posedge clk) begin
    if (!rstn || (state_q != sasp_pkg::ST_CONV)) begin
      conv_cnt_q <= 14'd0;
    end else if (conv_step) begin
      conv_cnt_q <= conv_cnt_q + 14'd1;       // 44 conversion clock falls, or CONV_CYC clk cycles internal
    end
  end

  // ---------------------------------------------------------------
  // Result, address and outputs
  // ---------------------------------------------------------------
  logic [sasp_pkg::RES_W-1:0]  result_q;  // Last finished result
  logic [sasp_pkg::ADDR_W-1:0] addr_q;    // Address for next conversion
  logic [3:0]                  bit_idx;   // Result bit on the pin
  logic                        undef_q;   // No result yet

  assign bit_idx = 4'(sasp_pkg::RES_W - 1) - pos_q[3:0];

  // Final conversion step writes the result; an abort on that step wins
  always_ff @(posedge clk) begin
    if (!rstn) begin
      result_q <= sasp_pkg::RESULT_RST;
      undef_q  <= 1'b1;
    end else if (conv_done && !qual_fall) begin
      result_q <= conv_result;
      undef_q  <= 1'b0;
    end
  end

  // Address shifted in MSB first on the first four rises
  always_ff @(posedge clk) begin
    if (!rstn) begin
      addr_q <= sasp_pkg::ADDR_RST;
    end else if (rise_ev && cs_sel && (state_q == sasp_pkg::ST_SHIFT) && (rpos_q != 3'd4)) begin
      addr_q <= {addr_q[sasp_pkg::ADDR_W-2:0], ring_bit};
    end
  end

  // Serial output data and enable
  always_ff @(posedge clk) begin
    if (!rstn) begin
      dout      <= 1'b0;
      dout_oe_n <= 1'b1;
    end else begin
      dout_oe_n <= cs_lvl_q;                  // Float while deselected
      if (cs_sel && (state_q != sasp_pkg::ST_IDLE) && (pos_q < POS_TEN)) begin
        dout <= result_q[bit_idx];            // MSB first, one bit per fall
      end else begin
        dout <= 1'b0;                         // Zero fill after tenth fall
      end
    end
  end

  // Completion flag, internal variant only
  always_ff @(posedge clk) begin
    if (!rstn || !INTERNAL_OSC) begin
      eoc <= 1'b1;
    end else if (enter_conv && !start_port) begin
      eoc <= 1'b0;
    end else if (state_q != sasp_pkg::ST_CONV) begin
      eoc <= 1'b1;                            // Result ready or aborted
    end
  end

  // Analog core controls
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ana            <= '0;
      data_undefined <= 1'b1;
    end else begin
      ana.sample     <= (state_q == sasp_pkg::ST_SHIFT) && (pos_q >= POS_SMP);
      ana.hold       <= state_q == sasp_pkg::ST_CONV;
      ana.chan       <= addr_q;
      data_undefined <= undef_q;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_sel_start;
    (state_q == sasp_pkg::ST_SHIFT) && (pos_q == 5'd0) && cs_sel;
  endsequence

  property p_float_deselected;
    $past(cs_lvl_q) |-> dout_oe_n;
  endproperty
  a_float_deselected: assert property (p_float_deselected) else $error("output driven while deselected");

  property p_start_aligns;
    start_port |=> (state_q == sasp_pkg::ST_SHIFT) && (pos_q == 5'd0) && (rpos_q == 3'd0);
  endproperty
  a_start_aligns: assert property (p_start_aligns) else $error("start did not realign port");

  property p_cs_qualified;
    $changed(cs_lvl_q) |-> (cs_lvl_q == $past(cs_s2_q)) && (INTERNAL_OSC || $past(cc_fall));
  endproperty
  a_cs_qualified: assert property (p_cs_qualified) else $error("select level taken unqualified");

  property p_abort_keeps;
    (state_q == sasp_pkg::ST_CONV) && qual_fall |=> (state_q == sasp_pkg::ST_SHIFT) && $stable(result_q);
  endproperty
  a_abort_keeps: assert property (p_abort_keeps) else $error("abort lost previous result");

  property p_result_write;
    conv_done && !qual_fall |=> (result_q == $past(conv_result)) && !undef_q;
  endproperty
  a_result_write: assert property (p_result_write) else $error("result not written at completion");

  property p_msb_first;
    s_sel_start |=> dout == $past(result_q[sasp_pkg::RES_W-1]);
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("MSB not driven at start");

  property p_bit_order;
    cs_sel && (state_q != sasp_pkg::ST_IDLE) && (pos_q < POS_TEN) |=> dout == $past(result_q[bit_idx]);
  endproperty
  a_bit_order: assert property (p_bit_order) else $error("wrong result bit on output");

  property p_zero_fill;
    (pos_q >= POS_TEN) |=> !dout;
  endproperty
  a_zero_fill: assert property (p_zero_fill) else $error("nonzero bit after tenth fall");

  property p_tail_restart;
    tail_start |=> (state_q == sasp_pkg::ST_SHIFT) ##1 (dout == $past(result_q[sasp_pkg::RES_W-1]));
  endproperty
  a_tail_restart: assert property (p_tail_restart) else $error("16th fall did not restart");

  property p_addr_frozen;
    rise_ev && (rpos_q == 3'd4) |=> $stable(addr_q);
  endproperty
  a_addr_frozen: assert property (p_addr_frozen) else $error("address changed after four bits");

  property p_sample_window;
    ana.sample |-> ($past(pos_q) >= POS_SMP) && ($past(pos_q) < POS_TEN);
  endproperty
  a_sample_window: assert property (p_sample_window) else $error("sampling outside window");

  property p_eoc_low;
    INTERNAL_OSC && enter_conv && !start_port |=> !eoc throughout (state_q == sasp_pkg::ST_CONV) [*2];
  endproperty
  a_eoc_low: assert property (p_eoc_low) else $error("completion flag not low in conversion");

  property p_conv_span;
    (state_q == sasp_pkg::ST_CONV) |-> conv_cnt_q <= CONV_LIM;
  endproperty
  a_conv_span: assert property (p_conv_span) else $error("conversion ran past its length");

  c_select: cover property (qual_fall ##[1:100] (pos_q == POS_TEN));
  c_abort: cover property ((state_q == sasp_pkg::ST_CONV) && qual_fall);
  c_tail: cover property (tail_start);
  c_done_start: cover property (conv_done && start_port);

endmodule

// File: sasp_pkg.sv
// Shared constants and types for the serial ADC port sequencer
package sasp_pkg;

  // ---------------------------------------------------------------
  // Transfer framing
  // ---------------------------------------------------------------
  localparam int RES_W      = 10;  // Result width
  localparam int ADDR_W     = 4;   // Channel address width
  localparam int XFER_SHORT = 10;  // Falls that end the data field
  localparam int XFER_LONG  = 16;  // Falls of a long transfer
  localparam int SAMPLE_POS = 4;   // Fall that opens the sample window

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_NS      = 4;   // System clock period, ns
  localparam int CONV_STEPS  = 44;  // Conversion clocks per conversion
  localparam int CS_EDGES    = 2;   // Conversion clock falls to qualify
  localparam int CS_FILT_MS  = 2;   // Chip select persistence, ms
  localparam int CONV_INT_US = 44;  // Internal conversion time, us
  localparam int CS_FILT_CYC_DEF = (CS_FILT_MS * 1000000 + CLK_NS - 1) / CLK_NS;
  localparam int CONV_CYC_DEF    = (CONV_INT_US * 1000 + CLK_NS - 1) / CLK_NS;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [RES_W-1:0]  RESULT_RST = 10'h000;
  localparam logic [ADDR_W-1:0] ADDR_RST   = 4'h0;

  // Sequencer states
  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,  // No transfer in progress
    ST_SHIFT = 4'h2,  // Shifting the first ten bits
    ST_CONV  = 4'h4,  // Conversion running
    ST_TAIL  = 4'h8   // Waiting for the 16th fall
  } sasp_state_t;

  // Controls toward the analog core
  typedef struct packed {
    logic              sample;  // Input connected to the DAC
    logic              hold;    // Hold and convert
    logic [ADDR_W-1:0] chan;    // Selected channel or test code
  } sasp_ana_t;

endpackage

// File: sasp_host.sv
// Host serial master model for the converter's serial port
`timescale 1ns/1ps
module sasp_host #(
  parameter realtime HALF = 62.5  // Half period of the link clock
) (
  output logic      cs_n,
  output logic      sclk,
  output logic      din,
  input  wire logic dout
);
  logic [15:0] rx_q;  // Bits read on rises, oldest first

  // ---------------------------------------------------------------
  // Idle levels: deselected, link clock still
  // ---------------------------------------------------------------
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    din  = 1'b0;
    rx_q = 16'h0000;
  end

  // Change select, then leave time for qualification
  task automatic sel(input logic lvl);
    cs_n = lvl;
    #(400);
  endtask

  // ---------------------------------------------------------------
  // One burst of clocks; address on first four rises
  // ---------------------------------------------------------------
  // Clock never pauses within one burst
  // Callers send bursts of 4, 6, 8 or 10 clocks
  task automatic clocks(input logic [3:0] addr, input int n);
    for (int i = 0; i < n; i++) begin
      din = (i < 4) ? addr[3-i] : ~din;  // Toggles once the address is in
      #(HALF);
      sclk = 1'b1;
      rx_q = {rx_q[14:0], dout};  // Read on the rise
      #(HALF);
      sclk = 1'b0;
    end
  endtask
endmodule

// File: sasp_port_tb.sv
// Self-checking testbench of the serial ADC port sequencer
`timescale 1ns/1ps
module sasp_port_tb;
  logic                       clk;
  logic                       rstn;
  logic                       conversion_clock;
  logic [sasp_pkg::RES_W-1:0] conv_result;
  logic                       cs_n;
  logic                       sclk;
  logic                       din;
  logic                       dout;
  logic                       dout_oe_n;
  logic                       eoc;
  logic                       data_undefined;
  sasp_pkg::sasp_ana_t        ana;
  logic                       osc_dout;
  logic                       osc_oe_n;
  logic                       osc_eoc;
  logic                       osc_undef;
  sasp_pkg::sasp_ana_t        osc_ana;
  int                         error_cnt;
  int                         tests_run;
  int                         cyc;

  // ---------------------------------------------------------------
  // Clocks and instances
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Free-running conversion clock, unrelated phase
  initial begin
    conversion_clock = 1'b0;
    #7;
    forever #20 conversion_clock = ~conversion_clock;
  end

  sasp_port sasp_port_i (.clk(clk), .rstn(rstn), .sclk(sclk), .cs_n(cs_n), .din(din),
    .conversion_clock(conversion_clock), .conv_result(conv_result), .dout(dout),
    .dout_oe_n(dout_oe_n), .eoc(eoc), .data_undefined(data_undefined), .ana(ana));
  // Internal oscillator variant on the same link, short filter and conversion
  sasp_port #(.INTERNAL_OSC(1'b1), .CS_FILT_CYC(20), .CONV_CYC(60)) sasp_port_osc_i (.clk(clk), .rstn(rstn),
    .sclk(sclk), .cs_n(cs_n), .din(din), .conversion_clock(conversion_clock), .conv_result(conv_result),
    .dout(osc_dout), .dout_oe_n(osc_oe_n), .eoc(osc_eoc), .data_undefined(osc_undef), .ana(osc_ana));
  sasp_host sasp_host_i (.cs_n(cs_n), .sclk(sclk), .din(din), .dout(dout));

  // ---------------------------------------------------------------
  // Checking and closing
  // ---------------------------------------------------------------
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("Checks %0d, errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      test_done();
    end
  end

  // Wait, bounded, for hold to start and then end; returns cycles in hold
  task automatic wait_done(output int n);
    for (n = 0; n < 100 && ana.hold !== 1'b1; n++) @(posedge clk);
    for (n = 0; n < 1000 && ana.hold !== 1'b0; n++) @(posedge clk);
    #50;
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    check("oe_n", dout_oe_n, 1'b1);
    check("eoc", eoc, 1'b1);
    check("undef", data_undefined, 1'b1);
    check("ana", ana, 6'h00);
    check("osc oe_n", osc_oe_n, 1'b1);
    check("osc eoc", osc_eoc, 1'b1);
  endtask

  // Clocks while deselected change nothing
  task automatic t_idle();
    sasp_host_i.clocks(4'hF, 6);
    #50;
    check("idle oe_n", dout_oe_n, 1'b1);
    check("idle ana", ana, 6'h00);
  endtask

  // First transfer, address, sample window and conversion time
  task automatic t_first();
    int n;
    conv_result = 10'h2B5;
    sasp_host_i.sel(1'b0);
    check("sel oe_n", dout_oe_n, 1'b0);
    check("osc sel oe_n", osc_oe_n, 1'b0);
    sasp_host_i.clocks(4'hA, 4);
    #50;
    check("chan", ana.chan, 4'hA);
    check("sampling", ana.sample, 1'b1);
    sasp_host_i.clocks(4'h5, 6);
    #50;
    check("chan kept", ana.chan, 4'hA);
    check("hold", {ana.sample, ana.hold}, 2'b01);
    check("zero out", dout, 1'b0);
    check("undef mid", data_undefined, 1'b1);
    check("osc eoc low", osc_eoc, 1'b0);
    wait_done(n);
    check("conv time", (n >= 410 && n <= 450), 1'b1);
    check("undef end", data_undefined, 1'b0);
    check("osc eoc high", osc_eoc, 1'b1);
    check("osc undef", osc_undef, 1'b0);
    sasp_host_i.sel(1'b1);
    check("desel oe_n", dout_oe_n, 1'b1);
    check("osc desel", osc_oe_n, 1'b1);
  endtask

  // Sixteen clocks in two bursts of eight
  task automatic t_read16();
    int n;
    conv_result = 10'h3C3;
    sasp_host_i.sel(1'b0);
    sasp_host_i.clocks(4'h3, 8);
    sasp_host_i.clocks(4'hC, 8);
    #50;
    check("rx16", sasp_host_i.rx_q, {10'h2B5, 6'h00});
    check("chan3", ana.chan, 4'h3);
    check("conv zero", dout, 1'b0);
    check("osc tail msb", {osc_oe_n, osc_dout}, 2'b01);
    wait_done(n);
    sasp_host_i.sel(1'b1);
  endtask

  // Select during conversion aborts and keeps the older result
  task automatic t_abort();
    int n;
    sasp_host_i.sel(1'b0);
    sasp_host_i.clocks(4'h2, 10);
    sasp_host_i.sel(1'b1);
    conv_result = 10'h0FF;
    sasp_host_i.sel(1'b0);
    check("aborted", ana.hold, 1'b0);
    sasp_host_i.clocks(4'h2, 10);
    check("old kept", sasp_host_i.rx_q[9:0], 10'h3C3);
    wait_done(n);
    sasp_host_i.sel(1'b1);
  endtask

  // Select held low: new result appears at completion
  task automatic t_held();
    int n;
    sasp_host_i.sel(1'b0);
    sasp_host_i.clocks(4'h0, 10);
    check("rx held", sasp_host_i.rx_q[9:0], 10'h0FF);
    conv_result = 10'h3AA;
    wait_done(n);
    check("new msb", {dout_oe_n, dout}, 2'b01);
    sasp_host_i.clocks(4'h0, 10);
    check("rx next", sasp_host_i.rx_q[9:0], 10'h3AA);
    wait_done(n);
    sasp_host_i.sel(1'b1);
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    rstn        = 1'b1;  // Starts high so a clean fall clears the link counters
    conv_result = 10'h000;
    error_cnt   = 0;
    tests_run   = 0;
    cyc         = 0;
    #1 rstn = 1'b0;
    repeat (4) @(posedge clk);
    #1 rstn = 1'b1;
    @(posedge clk);
    #1;
    t_reset();
    t_idle();
    t_first();
    t_read16();
    t_abort();
    t_held();
    test_done();
  end
endmodule
